// file: hdl/lb_initiator.sv
// Loopback initiator: starts a test stream, checks the data that comes back.
// Assumes link clock from the bench; i_start is a one-cycle pulse on i_clk_sys.
`timescale 1ns/1ns
`include "lb_map.svh"
module lb_initiator (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_start,
    input  wire logic       i_analog,
    input  wire logic [1:0] i_oob,
    output logic            o_active,
    output logic            o_locked,
    output logic            o_err,
    lb_link_if.initiator    link
);
    lb_pkg::ini_link_t lk;
    lb_pkg::ini_link_t lk_nxt;
    lb_pkg::ini_sys_t  sy;
    lb_pkg::ini_sys_t  sy_nxt;
    lb_pkg::lword_t    rx;

    always_comb begin
        sy_nxt        = sy;
        sy_nxt.act_s  = {sy.act_s[0], lk.active};
        sy_nxt.lock_s = {sy.lock_s[0], lk.locked};
        sy_nxt.err_s  = {sy.err_s[0], lk.err};
        sy_nxt.active = sy.act_s[1];
        sy_nxt.locked = sy.lock_s[1];
        sy_nxt.err    = sy.err_s[1];
        sy_nxt.oob    = i_oob;
        if (i_start) begin
            // Mode is held steady while the toggle crosses
            sy_nxt.mode_an   = i_analog;
            sy_nxt.start_tgl = ~sy.start_tgl;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sy <= '0;
        end else begin
            sy <= sy_nxt;
        end
    end

    assign o_active = sy.active;
    assign o_locked = sy.locked;
    assign o_err    = sy.err;

    always_comb begin
        lk_nxt        = lk;
        lk_nxt.rst_s  = {lk.rst_s[0], i_rst};
        lk_nxt.tgl_s  = {lk.tgl_s[1:0], sy.start_tgl};
        lk_nxt.oob_s1 = sy.oob;
        lk_nxt.oob_s2 = lk.oob_s1;
        rx            = '{k: link.d2i_k, dw: link.d2i_dw};
        lk_nxt.tx_rd  = lb_pkg::rd_after(lk.tx_rd, lk.tx_w);
        lk_nxt.tx_cnt = (lk.tx_cnt == `LB_ALIGN_PERIOD - 9'h001) ? 9'h000 : lk.tx_cnt + 9'h001;
        case (lk.st)
            lb_pkg::IS_IDLE: begin
                lk_nxt.tx_w = (lk.tx_cnt < `LB_PAIR_LEN) ? lb_pkg::prim(`LB_ALIGN_CODE)
                                                         : lb_pkg::prim(`LB_SYNC_CODE);
                if (lk.tgl_s[2] != lk.tgl_s[1] && lk.oob_s2 == `LB_OOB_NONE) begin
                    lk_nxt.st        = lb_pkg::IS_ACTIVE;
                    lk_nxt.mode_an   = sy.mode_an;
                    lk_nxt.bist_pend = 1'b1;
                    lk_nxt.locked    = 1'b0;
                    lk_nxt.err       = 1'b0;
                    lk_nxt.active    = 1'b1;
                end
            end
            lb_pkg::IS_ACTIVE: begin
                if (lk.bist_pend) begin
                    lk_nxt.tx_w      = '{k: 1'b1, dw: {lk.mode_an ? `LB_MODE_ANALOG : `LB_MODE_RETIMED,
                                                       `LB_BIST_TAG}}; // R01
                    lk_nxt.bist_pend = 1'b0;
                    lk_nxt.tx_cnt    = 9'h000;
                    lk_nxt.pat       = 32'h0000_0000;
                end else if (lk.tx_cnt < `LB_DUAL_BURST) begin
                    // One burst of four per period covers up to two consumed
                    lk_nxt.tx_w = lb_pkg::prim(`LB_ALIGN_CODE); // R06 R07
                end else begin
                    lk_nxt.tx_w = '{k: 1'b0, dw: lk.pat}; // R12
                    lk_nxt.pat  = lk.pat + 32'h0000_0001;
                end
                // Primitive positions are ignored; only data order is checked
                if (link.d2i_valid && !rx.k) begin // R11
                    lk_nxt.locked = 1'b1;
                    lk_nxt.exp    = rx.dw + 32'h0000_0001;
                    if (lk.locked && rx.dw != lk.exp) begin // R13
                        lk_nxt.err = 1'b1;
                    end
                end
            end
            default: lk_nxt.st = lb_pkg::IS_IDLE;
        endcase
        if (lk.oob_s2 != `LB_OOB_NONE) begin
            lk_nxt.st        = lb_pkg::IS_IDLE;
            lk_nxt.active    = 1'b0;
            lk_nxt.bist_pend = 1'b0;
        end
    end

    always_ff @(posedge link.clk_link) begin
        if (lk.rst_s[1]) begin
            lk       <= '0;
            lk.st    <= lb_pkg::IS_IDLE;
            lk.rst_s <= lk_nxt.rst_s;
            lk.tgl_s <= lk_nxt.tgl_s;
        end else begin
            lk <= lk_nxt;
        end
    end

    assign link.i2d_valid = ~lk.rst_s[1];
    assign link.i2d_k     = lk.tx_w.k;
    assign link.i2d_dw    = lk.tx_w.dw;
    assign link.i2d_rd    = lk.tx_rd;
    assign link.i2d_oob   = lk.oob_s2;
endmodule

// file: hdl/lb_link_if.sv
// Serial link between loopback initiator and looping end, at DWORD level.
// Assumes the bench supplies the link clock and joins the two ends here.
`timescale 1ns/1ns
interface lb_link_if (
    input wire logic clk_link
);
    logic        i2d_valid;
    logic        i2d_k;
    logic [31:0] i2d_dw;
    logic        i2d_rd;
    logic [1:0]  i2d_oob;
    logic        d2i_valid;
    logic        d2i_k;
    logic [31:0] d2i_dw;
    logic        d2i_rd;

    modport looper (
        input  clk_link, i2d_valid, i2d_k, i2d_dw, i2d_rd, i2d_oob,
        output d2i_valid, d2i_k, d2i_dw, d2i_rd
    );
    modport initiator (
        input  clk_link, d2i_valid, d2i_k, d2i_dw, d2i_rd,
        output i2d_valid, i2d_k, i2d_dw, i2d_rd, i2d_oob
    );
endinterface

// file: hdl/lb_looper.sv
// Looping end of the serial link: normal ALIGN cadence, retimed and analog loopback.
// Assumes link clock from the bench and an initiator on the far side of lb_link_if.
`timescale 1ns/1ns
`include "lb_map.svh"
// Summary of operation
// [R01] Enter loopback only on BIST activation
// [R02] Stay looping until COMRESET or COMINIT
// [R03] Recover stream, retransmit with retiming ALIGNs
// [R04] Descrambled data must be rescrambled identically
// [R05] Returned data equals received; disparity may differ
// [R06] Initiator allows two ALIGNs consumed per 256
// [R07] Initiator sends extra ALIGNs as one burst
// [R08] Drop zero to two ALIGNs per burst
// [R09] Insert adjacent, else at least two ALIGNs
// [R10] Returned ALIGN bursts at least two long
// [R11] Initiator ignores returned ALIGN positions
// [R12] Initiator sends only valid characters
// [R13] Initiator compares decoded data, not raw
// [R14] Return content unchanged, ignore primitive protocol
// [R15] Act only on OOB and ALIGN while looping
// [R16] Analog loopback: BIST entry, OOB exit
// [R17] Near-end analog needs silent far end
// [R18] Normal transmit: ALIGN pairs, 254 gap max
// [R19] Accept either disparity after diagnostic exit
// [R20] OOB stops retransmit, restarts link init
module lb_looper (
    input  wire logic    i_clk_sys,
    input  wire logic    i_rst,
    output logic         o_looping,
    output logic         o_analog,
    output logic         o_rd_err,
    lb_link_if.looper    link
);
    lb_pkg::dev_link_t lk;
    lb_pkg::dev_link_t lk_nxt;
    lb_pkg::dev_sys_t  sy;
    lb_pkg::dev_sys_t  sy_nxt;
    lb_pkg::lword_t    rx;
    lb_pkg::lword_t    head;
    logic              rx_align;
    logic              drop;
    logic              push;
    logic              pop;

    localparam lb_pkg::dev_link_t LK_RST = '{st: lb_pkg::DS_INIT, rd_free: 1'b1, default: '0};

    // Link clock domain
    always_comb begin
        lk_nxt       = lk;
        lk_nxt.rst_s = {lk.rst_s[0], i_rst};
        rx           = '{k: link.i2d_k, dw: link.i2d_dw};
        head         = lb_pkg::lword_t'(lk.ebuf[lk.rd_ptr]);
        rx_align     = link.i2d_valid && lb_pkg::is_align(rx);
        drop         = 1'b0;
        push         = 1'b0;
        pop          = 1'b0;

        // Either disparity is accepted on the first word after a diagnostic exit
        if (link.i2d_valid) begin
            if (!lk.rd_free && link.i2d_rd != lk.rd_exp) begin // R19
                lk_nxt.rd_err_tgl = ~lk.rd_err_tgl;
            end
            lk_nxt.rd_exp  = lb_pkg::rd_after(link.i2d_rd, rx);
            lk_nxt.rd_free = 1'b0;
        end

        if (rx_align) begin
            lk_nxt.in_burst = (lk.in_burst == 3'h7) ? lk.in_burst : lk.in_burst + 3'h1;
        end else begin
            lk_nxt.in_burst = 3'h0;
            lk_nxt.dropped  = 2'h0;
        end

        lk_nxt.tx_valid = 1'b1;
        lk_nxt.tx_rd    = lb_pkg::rd_after(lk.tx_rd, lk.tx_w); // R05
        lk_nxt.tx_w     = lb_pkg::prim(`LB_ALIGN_CODE);

        case (lk.st)
            lb_pkg::DS_INIT: begin
                lk_nxt.init_cnt = lk.init_cnt + 8'h01;
                if (lk.init_cnt == `LB_INIT_WORDS - 8'h01) begin
                    lk_nxt.st     = lb_pkg::DS_NORMAL;
                    lk_nxt.tx_cnt = 9'h000;
                end
            end
            lb_pkg::DS_NORMAL: begin
                if (lk.tx_cnt >= `LB_PAIR_LEN) begin // R18
                    lk_nxt.tx_w = lb_pkg::prim(`LB_SYNC_CODE);
                end
                lk_nxt.tx_cnt = (lk.tx_cnt == `LB_ALIGN_PERIOD - 9'h001) ? 9'h000
                                                                        : lk.tx_cnt + 9'h001; // R18
                if (link.i2d_valid && rx.k && rx.dw[15:0] == `LB_BIST_TAG) begin
                    if (rx.dw[31:16] == `LB_MODE_RETIMED) begin
                        lk_nxt.st        = lb_pkg::DS_LOOP_RT; // R01
                        lk_nxt.loop_flag = 1'b1;
                        lk_nxt.ins       = 2'h2;
                        lk_nxt.fill      = 3'h0;
                        lk_nxt.wr_ptr    = 2'h0;
                        lk_nxt.rd_ptr    = 2'h0;
                        lk_nxt.tx_cnt    = 9'h000;
                    end else if (rx.dw[31:16] == `LB_MODE_ANALOG) begin
                        lk_nxt.st        = lb_pkg::DS_LOOP_AN; // R16
                        lk_nxt.loop_flag = 1'b1;
                        lk_nxt.an_flag   = 1'b1;
                    end
                end
            end
            lb_pkg::DS_LOOP_RT: begin
                // Only the third and later ALIGN of a burst go, so two always survive
                drop = rx_align && lk.in_burst >= `LB_BURST_KEEP && lk.dropped < `LB_DROP_MAX
                       && lk.fill >= `LB_FILL_LOW; // R08 R10
                if (drop) begin
                    lk_nxt.dropped = lk.dropped + 2'h1;
                end
                // Everything else, primitives included, is stored verbatim
                push = link.i2d_valid && !drop; // R14 R15
                if (lk.ins != 2'h0) begin
                    lk_nxt.ins    = lk.ins - 2'h1; // R09
                    lk_nxt.tx_cnt = 9'h000;
                end else if (lk.fill == 3'h0) begin
                    lk_nxt.ins    = 2'h1; // R09
                    lk_nxt.tx_cnt = 9'h000;
                end else if (lk.tx_cnt >= `LB_RETIME_AT && !lb_pkg::is_align(head)
                             && lk.fill <= `LB_FILL_LOW) begin
                    // Retiming pair; later drops give back the slack it creates
                    lk_nxt.ins    = 2'h1; // R03 R09
                    lk_nxt.tx_cnt = 9'h000;
                end else begin
                    pop         = 1'b1;
                    // Raw words go back out, so no scrambler state can diverge
                    lk_nxt.tx_w = head; // R03 R04 R05
                    lk_nxt.tx_cnt = lb_pkg::is_align(head) ? 9'h000 : lk.tx_cnt + 9'h001;
                end
            end
            lb_pkg::DS_LOOP_AN: begin
                // No retiming at all: the word goes back as received
                lk_nxt.tx_w     = rx; // R16
                lk_nxt.tx_rd    = link.i2d_rd;
                lk_nxt.tx_valid = link.i2d_valid;
            end
            default: begin
                lk_nxt.st       = lb_pkg::DS_INIT;
                lk_nxt.init_cnt = 8'h00;
            end
        endcase

        if (push) begin
            lk_nxt.ebuf[lk.wr_ptr] = rx;
            lk_nxt.wr_ptr          = lk.wr_ptr + 2'h1;
        end
        if (pop) begin
            lk_nxt.rd_ptr = lk.rd_ptr + 2'h1;
        end
        lk_nxt.fill = lk.fill + {2'h0, push} - {2'h0, pop};

        // OOB overrides everything, in any state, from this very word
        if (link.i2d_oob == `LB_OOB_COMRESET || link.i2d_oob == `LB_OOB_COMINIT) begin
            // Stays free for the whole OOB run, not just its first word
            if (lk.loop_flag || lk.rd_free) begin
                lk_nxt.rd_free = 1'b1; // R19
            end
            lk_nxt.st        = lb_pkg::DS_INIT; // R02 R16 R20
            lk_nxt.init_cnt  = 8'h00;
            lk_nxt.loop_flag = 1'b0;
            lk_nxt.an_flag   = 1'b0;
            lk_nxt.ins       = 2'h0;
            lk_nxt.fill      = 3'h0;
            lk_nxt.wr_ptr    = 2'h0;
            lk_nxt.rd_ptr    = 2'h0;
            lk_nxt.tx_valid  = 1'b1;
            lk_nxt.tx_w      = lb_pkg::prim(`LB_ALIGN_CODE); // R20
        end
    end

    always_ff @(posedge link.clk_link) begin
        if (lk.rst_s[1]) begin
            lk       <= LK_RST;
            lk.rst_s <= lk_nxt.rst_s;
        end else begin
            lk <= lk_nxt;
        end
    end

    assign link.d2i_valid = lk.tx_valid;
    assign link.d2i_k     = lk.tx_w.k;
    assign link.d2i_dw    = lk.tx_w.dw;
    assign link.d2i_rd    = lk.tx_rd;

    // System clock domain: status levels and the disparity error event
    always_comb begin
        sy_nxt           = sy;
        sy_nxt.loop_s    = {sy.loop_s[0], lk.loop_flag};
        sy_nxt.an_s      = {sy.an_s[0], lk.an_flag};
        sy_nxt.err_s     = {sy.err_s[1:0], lk.rd_err_tgl};
        sy_nxt.looping   = sy.loop_s[1];
        sy_nxt.analog    = sy.an_s[1];
        sy_nxt.rd_err    = sy.err_s[2] ^ sy.err_s[1];
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sy <= '0;
        end else begin
            sy <= sy_nxt;
        end
    end

    assign o_looping = sy.looping;
    assign o_analog  = sy.analog;
    assign o_rd_err  = sy.rd_err;
endmodule

// file: hdl/lb_map.svh
// Named constants for the retimed loopback link: primitive codes, modes, counts.
// Assumes a DWORD-level link model: one 32-bit word plus a primitive flag per link clock.
`ifndef LB_MAP_SVH
`define LB_MAP_SVH
`define LB_ALIGN_CODE   32'h0000_0A11
`define LB_SYNC_CODE    32'h0000_0511
`define LB_BIST_TAG     16'h0B15
`define LB_MODE_RETIMED 16'h0001
`define LB_MODE_ANALOG  16'h0002
`define LB_OOB_NONE     2'h0
`define LB_OOB_COMRESET 2'h1
`define LB_OOB_COMINIT  2'h2
`define LB_ALIGN_PERIOD 9'h100
`define LB_PAIR_LEN     9'h002
`define LB_DUAL_BURST   9'h004
`define LB_RETIME_AT    9'h0F0
`define LB_DROP_MAX     2'h2
`define LB_BURST_KEEP   3'h2
`define LB_FILL_LOW     3'h2
`define LB_INIT_WORDS   8'h10
`endif

// file: hdl/lb_pkg.sv
// Types and helpers shared by both ends of the loopback link.
// Assumes lb_map.svh is on the include path.
`include "lb_map.svh"
package lb_pkg;
    typedef struct packed {
        logic        k;
        logic [31:0] dw;
    } lword_t;

    typedef enum logic [3:0] {
        DS_NORMAL  = 4'h1,
        DS_LOOP_RT = 4'h2,
        DS_LOOP_AN = 4'h4,
        DS_INIT    = 4'h8
    } dev_state_t;

    typedef enum logic [1:0] {
        IS_IDLE   = 2'h1,
        IS_ACTIVE = 2'h2
    } ini_state_t;

    typedef struct packed {
        logic [1:0]       rst_s;
        dev_state_t       st;
        logic [8:0]       tx_cnt;
        logic [7:0]       init_cnt;
        logic [3:0][32:0] ebuf;
        logic [2:0]       fill;
        logic [1:0]       wr_ptr;
        logic [1:0]       rd_ptr;
        logic [2:0]       in_burst;
        logic [1:0]       dropped;
        logic [1:0]       ins;
        logic             rd_free;
        logic             rd_exp;
        logic             rd_err_tgl;
        logic             loop_flag;
        logic             an_flag;
        logic             tx_valid;
        lword_t           tx_w;
        logic             tx_rd;
    } dev_link_t;

    typedef struct packed {
        logic [1:0] loop_s;
        logic [1:0] an_s;
        logic [2:0] err_s;
        logic       looping;
        logic       analog;
        logic       rd_err;
    } dev_sys_t;

    typedef struct packed {
        logic [1:0] rst_s;
        ini_state_t st;
        logic [2:0] tgl_s;
        logic       mode_an;
        logic [1:0] oob_s1;
        logic [1:0] oob_s2;
        logic [8:0] tx_cnt;
        logic [31:0] pat;
        logic       bist_pend;
        logic       locked;
        logic [31:0] exp;
        logic       err;
        logic       active;
        lword_t     tx_w;
        logic       tx_rd;
    } ini_link_t;

    typedef struct packed {
        logic       mode_an;
        logic       start_tgl;
        logic [1:0] oob;
        logic [1:0] act_s;
        logic [1:0] lock_s;
        logic [1:0] err_s;
        logic       active;
        logic       locked;
        logic       err;
    } ini_sys_t;

    function automatic logic is_align(input lword_t w);
        return w.k && (w.dw == `LB_ALIGN_CODE);
    endfunction

    // Stand-in for the 8b/10b disparity walk: flips on odd weight
    function automatic logic rd_after(input logic rd, input lword_t w);
        return rd ^ (^w);
    endfunction

    function automatic lword_t prim(input logic [31:0] code);
        return '{k: 1'b1, dw: code};
    endfunction
endpackage

// file: tb/lb_link_sva.sv
// Checker for the loopback link.
// Assumes lb_map.svh on the include path; watches link signals only.
`timescale 1ns/1ns
`include "lb_map.svh"
module lb_link_sva (
    input wire logic        clk_link,
    input wire logic        i_rst,
    input wire logic        i2d_valid,
    input wire logic        i2d_k,
    input wire logic [31:0] i2d_dw,
    input wire logic [1:0]  i2d_oob,
    input wire logic        d2i_valid,
    input wire logic        d2i_k,
    input wire logic [31:0] d2i_dw
);
    logic        i_al;
    logic        d_al;
    logic        bist;
    logic        rt_r;
    logic        an_r;
    logic [1:0]  age_r;
    logic [8:0]  gap_d_r;
    logic [8:0]  gap_i_r;
    logic [32:0] q_r [8];
    logic [2:0]  wp_r;
    logic [2:0]  rp_r;

    assign i_al = i2d_valid && i2d_k && i2d_dw == `LB_ALIGN_CODE;
    assign d_al = d2i_valid && d2i_k && d2i_dw == `LB_ALIGN_CODE;
    assign bist = i2d_valid && i2d_k && i2d_dw[15:0] == `LB_BIST_TAG;

    // Shadow loop state and queue for word compare
    always_ff @(posedge clk_link) begin
        if (i_rst || i2d_oob != `LB_OOB_NONE) begin
            rt_r  <= 1'b0;
            an_r  <= 1'b0;
            age_r <= 2'h0;
            wp_r  <= 3'h0;
            rp_r  <= 3'h0;
        end else begin
            if (bist && !rt_r && !an_r) begin
                rt_r <= i2d_dw[31:16] == `LB_MODE_RETIMED;
                an_r <= i2d_dw[31:16] == `LB_MODE_ANALOG;
            end
            if ((rt_r || an_r) && age_r != 2'h3) begin
                age_r <= age_r + 2'h1;
            end
            if (rt_r && i2d_valid && !i_al) begin
                q_r[wp_r] <= {i2d_k, i2d_dw};
                wp_r      <= wp_r + 3'h1;
            end
            if (rt_r && age_r == 2'h3 && d2i_valid && !d_al) begin
                rp_r <= rp_r + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_link) begin
        gap_d_r <= (i_rst || d_al) ? 9'h000 : gap_d_r + {8'h00, d2i_valid};
        gap_i_r <= (i_rst || i_al) ? 9'h000 : gap_i_r + {8'h00, i2d_valid};
    end

    default clocking cb @(posedge clk_link);
    endclocking
    default disable iff (i_rst);

    chk_no_loop: assert property (!rt_r && !an_r && d2i_valid |->
        d2i_k && (d2i_dw == `LB_ALIGN_CODE || d2i_dw == `LB_SYNC_CODE))
        else $error("data returned outside loopback");
    chk_loop_data: assert property (rt_r && age_r == 2'h3 && d2i_valid && !d_al |->
        wp_r != rp_r && {d2i_k, d2i_dw} == q_r[rp_r])
        else $error("returned word differs");
    chk_burst_min: assert property (rt_r && age_r == 2'h3 && $rose(d_al) |=> d_al)
        else $error("short returned align burst");
    chk_analog_echo: assert property (an_r && age_r == 2'h3 |->
        d2i_k == $past(i2d_k) && d2i_dw == $past(i2d_dw))
        else $error("analog word not echoed");
    chk_oob_align: assert property (i2d_valid && i2d_oob != `LB_OOB_NONE |=> d_al)
        else $error("oob did not stop retransmit");
    chk_align_pair: assert property (!rt_r && !an_r && d_al && !$past(d_al) |=> d_al)
        else $error("unpaired align outside loopback");
    chk_gap_dev: assert property (!rt_r && !an_r |-> gap_d_r <= 9'h0FE)
        else $error("looper align gap too long");
    // One spare word for the activation word
    chk_gap_ini: assert property (gap_i_r <= 9'h0FF)
        else $error("initiator align gap too long");
    chk_ini_chars: assert property (i2d_valid && i2d_k |->
        i2d_dw == `LB_ALIGN_CODE || i2d_dw == `LB_SYNC_CODE || i2d_dw[15:0] == `LB_BIST_TAG)
        else $error("initiator sent unknown primitive");

    cov_retimed: cover property ($rose(rt_r));
    cov_analog: cover property ($rose(an_r));
    cov_data: cover property (rt_r && age_r == 2'h3 && !d_al);
    cov_oob: cover property ((rt_r || an_r) && i2d_oob != 2'h0);
endmodule

// file: tb/test_serial_link_retimed_loopback.sv
// Bench: initiator and looper joined, plus a second looper fed directly.
// Assumes the design files; link clock made here, free running.
`timescale 1ns/1ns
`include "lb_map.svh"
module test_serial_link_retimed_loopback;
    logic        i_clk_sys;
    logic        clk_link;
    logic        i_rst;
    logic        start;
    logic        analog;
    logic [1:0]  oob;
    logic        act;
    logic        locked;
    logic        err;
    logic        lp;
    logic        an;
    logic        lp_b;
    logic        rde_b;
    logic [31:0] rng;
    logic        rd2;
    logic        grab;
    logic [32:0] sent[$];
    logic [32:0] got[$];
    int          n_fail;
    int          compares;
    int          rde_n;

    lb_link_if u_link (.clk_link(clk_link));
    lb_link_if u_link_b (.clk_link(clk_link));
    lb_initiator i_lb_initiator (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_start(start), .i_analog(analog),
        .i_oob(oob), .o_active(act), .o_locked(locked), .o_err(err), .link(u_link.initiator));
    lb_looper i_lb_looper (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .o_looping(lp), .o_analog(an),
        .o_rd_err(), .link(u_link.looper));
    lb_looper i_lb_looper_b (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .o_looping(lp_b), .o_analog(),
        .o_rd_err(rde_b), .link(u_link_b.looper));
    lb_link_sva u_chk (.clk_link(clk_link), .i_rst(i_rst), .i2d_valid(u_link.i2d_valid), .i2d_k(u_link.i2d_k),
        .i2d_dw(u_link.i2d_dw), .i2d_oob(u_link.i2d_oob), .d2i_valid(u_link.d2i_valid),
        .d2i_k(u_link.d2i_k), .d2i_dw(u_link.d2i_dw));

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #37;
        forever #80 clk_link = ~clk_link;
    end
    always @(posedge i_clk_sys) begin
        if (rde_b === 1'b1) rde_n++;
    end
    // Capture from the first data word on; ALIGNs skipped
    always @(posedge clk_link) begin
        if (grab && u_link_b.d2i_valid && !(u_link_b.d2i_k && u_link_b.d2i_dw == `LB_ALIGN_CODE)
            && (got.size() > 0 || !u_link_b.d2i_k)) got.push_back({u_link_b.d2i_k, u_link_b.d2i_dw});
    end

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    function automatic logic flag(input int s);
        case (s)
            0: return locked;
            1: return lp;
            default: return lp_b;
        endcase
    endfunction
    task automatic tally_and_finish();
        $display("counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk_bit(input string nm, input logic exp, input logic seen);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", nm, exp, seen);
        end
    endtask
    task automatic chk_word(input string nm, input logic [32:0] exp, input logic [32:0] seen);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_flag(input string nm, input int s, input logic lvl);
        int n;
        n = 0;
        while (flag(s) !== lvl) begin
            @(posedge i_clk_sys);
            n++;
            if (n > 20000) begin
                n_fail++;
                $display("mismatch %s expected %b seen timeout", nm, lvl);
                tally_and_finish();
            end
        end
        compares++;
    endtask
    // Drives the second looper in the initiator's place
    task automatic drv(input logic k, input logic [31:0] dw, input logic [1:0] ob);
        @(posedge clk_link);
        u_link_b.i2d_valid <= 1'b1;
        u_link_b.i2d_k     <= k;
        u_link_b.i2d_dw    <= dw;
        u_link_b.i2d_rd    <= rd2;
        u_link_b.i2d_oob   <= ob;
        rd2 = rd2 ^ (^{k, dw});
        if (grab && !(k && dw == `LB_ALIGN_CODE)) sent.push_back({k, dw});
    endtask

    initial begin
        logic [31:0] r;
        i_rst = 1'b1;
        start = 1'b0;
        analog = 1'b0;
        oob = 2'h0;
        rng = 32'h0000_68B5;
        rd2 = 1'b0;
        grab = 1'b0;
        n_fail = 0;
        compares = 0;
        rde_n = 0;
        {u_link_b.i2d_valid, u_link_b.i2d_k, u_link_b.i2d_dw, u_link_b.i2d_rd, u_link_b.i2d_oob} = 37'h0_0000_0000;
        // Link side resyncs reset: hold it over link edges
        repeat (8) @(posedge clk_link);
        @(posedge i_clk_sys);
        i_rst <= 1'b0;
        for (int m = 0; m < 2; m++) begin
            // Looper must finish its init run first
            repeat (24) @(posedge clk_link);
            @(posedge i_clk_sys);
            analog <= m[0];
            start  <= 1'b1;
            @(posedge i_clk_sys);
            start <= 1'b0;
            wait_flag("looping", 1, 1'b1);
            wait_flag("locked", 0, 1'b1);
            chk_bit("analog flag", m[0], an);
            chk_bit("active", 1'b1, act);
            for (int i = 0; i < 5; i++) begin
                repeat (100) @(posedge clk_link);
                chk_bit("looping held", 1'b1, lp);
            end
            chk_bit("returned data error", 1'b0, err);
            @(posedge i_clk_sys);
            oob <= m[0] ? `LB_OOB_COMINIT : `LB_OOB_COMRESET;
            repeat (6) @(posedge clk_link);
            @(posedge i_clk_sys);
            oob <= `LB_OOB_NONE;
            wait_flag("loop exit", 1, 1'b0);
            chk_bit("active cleared", 1'b0, act);
            $display("test loop mode %0d done", m);
        end
        for (int i = 0; i < 8; i++) drv(1'b1, `LB_SYNC_CODE, `LB_OOB_NONE);
        drv(1'b1, {16'h0004, `LB_BIST_TAG}, `LB_OOB_NONE);
        for (int i = 0; i < 40; i++) drv(1'b1, `LB_SYNC_CODE, `LB_OOB_NONE);
        chk_bit("loop on unknown mode", 1'b0, lp_b);
        drv(1'b1, {`LB_MODE_RETIMED, `LB_BIST_TAG}, `LB_OOB_NONE);
        grab = 1'b1;
        for (int i = 0; i < 300; i++) begin
            r = xs();
            if (i % 256 < 4) drv(1'b1, `LB_ALIGN_CODE, `LB_OOB_NONE);
            else if (i == 4 || r[2:1] != 2'h0) drv(1'b0, xs(), `LB_OOB_NONE);
            else drv(1'b1, r[0] ? `LB_SYNC_CODE : {`LB_MODE_RETIMED, `LB_BIST_TAG}, `LB_OOB_NONE);
        end
        for (int i = 0; i < 12; i++) drv(1'b1, `LB_ALIGN_CODE, `LB_OOB_NONE);
        grab = 1'b0;
        chk_word("returned count", 33'(sent.size()), 33'(got.size()));
        foreach (sent[i]) chk_word("returned word", sent[i], i < got.size() ? got[i] : 33'h0_0000_0000);
        chk_bit("looping held", 1'b1, lp_b);
        chk_bit("no disparity error", 1'b1, rde_n == 0);
        for (int i = 0; i < 6; i++) drv(1'b1, `LB_ALIGN_CODE, `LB_OOB_COMINIT);
        wait_flag("loop exit", 2, 1'b0);
        rd2 = ~rd2;
        for (int i = 0; i < 20; i++) drv(1'b1, `LB_SYNC_CODE, `LB_OOB_NONE);
        chk_bit("either start disparity", 1'b1, rde_n == 0);
        rd2 = ~rd2;
        for (int i = 0; i < 4; i++) drv(1'b1, `LB_SYNC_CODE, `LB_OOB_NONE);
        repeat (2) @(posedge clk_link);
        chk_bit("disparity fault seen", 1'b1, rde_n != 0);
        $display("test direct looping end done");
        tally_and_finish();
    end
endmodule
